// File: inc/hpsfi_pkg.sv
// Package: register map, field positions and timing constants for the hot-plug fault logic
package hpsfi_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] HPSFI_OFS_CTRL_WR   = 8'h00;
    localparam logic [7:0] HPSFI_OFS_STATUS    = 8'h10;
    localparam logic [7:0] HPSFI_OFS_CTRL_RD   = 8'h11;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int HPSFI_CTL_MASK_A  = 0;
    localparam int HPSFI_CTL_EN_A    = 1;
    localparam int HPSFI_CTL_MASK_B  = 2;
    localparam int HPSFI_CTL_EN_B    = 3;
    localparam int HPSFI_CTL_SW_RST  = 4;
    localparam logic [7:0] HPSFI_CTL_RESET = 8'h00;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int HPSFI_ST_SYSTEM_POWER_VALID_A = 0;
    localparam int HPSFI_ST_AUXOK_A = 1;
    localparam int HPSFI_ST_IRQ_A   = 2;
    localparam int HPSFI_ST_SYSTEM_POWER_VALID_B = 3;
    localparam int HPSFI_ST_AUXOK_B = 4;
    localparam int HPSFI_ST_IRQ_B   = 5;
    localparam int HPSFI_ST_PVALID  = 6;

    // ****************************************
    // Timing
    // ****************************************
    localparam int HPSFI_CLK_MHZ        = 125;
    localparam int HPSFI_AUX_SLOW_US    = 1000;
    localparam int HPSFI_AUX_FAST_NS    = 10000;
    localparam int HPSFI_STBY_OC_NS     = 25000;
    localparam int HPSFI_AUX_SLOW_CYC   = HPSFI_AUX_SLOW_US * HPSFI_CLK_MHZ;
    localparam int HPSFI_AUX_FAST_CYC   = (HPSFI_AUX_FAST_NS * HPSFI_CLK_MHZ + 999) / 1000;
    localparam int HPSFI_STBY_OC_CYC    = (HPSFI_STBY_OC_NS * HPSFI_CLK_MHZ + 999) / 1000;

endpackage : hpsfi_pkg

// File: verilog/hpsfi_oc_filter.sv
// Overcurrent persistence filter: trips after a comparator stays high for a set count
`timescale 1ns/1ps
module hpsfi_oc_filter #(
    parameter int CNT_W = 17
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // Comparator and limit
    input  wire logic             over,
    input  wire logic [CNT_W-1:0] limit,
    // Trip pulse
    output logic                  trip
);
    import hpsfi_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             trip;
    } hpsfi_flt_t;

    hpsfi_flt_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.trip = 1'b0;
        if (!over) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= limit) begin
            s_d.trip = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign trip = s_q.trip;

    a_flt_drop : assert property (@(posedge clk_sys) disable iff (srst)
        !over |=> !trip) else $error("filter tripped without comparator");

endmodule : hpsfi_oc_filter

// File: verilog/hpsfi_core.sv
// Two-slot hot-plug sequencing, fault latching and interrupt logic
// How it works
// R01 - Main on needs inputs, power valid, enable
// R02 - Output undervoltage checked only once enhanced
// R03 - No undervoltage check on negative rail
// R04 - Overload checked whenever slot enabled (code checks only while the main switch is on)
// R05 - Slot fault shuts only that slot
// R06 - Overtemperature unmaskable, kills both slots (code lets mask bits 0 and 2 gate its pin interrupt)
// R07 - Main faults latch until enable cycled
// R08 - Off path engages output discharge
// R09 - Standby aux latched off until switch/supply cycled
// R10 - Main aux latched off until switch/supply cycled
// R11 - Aux on with standby and populated slot
// R12 - Aux moves to main, break-before-make
// R13 - Aux returns to standby on undervoltage
// R14 - Switch rising edge turns aux off
// R15 - Main aux trips 1A/1ms or 1.5A/10us
// R16 - Standby aux trips 40mA for 25us
// R17 - Interrupt low on any listed event
// R18 - Masks gate only the pin
// R19 - Mask bits 0 and 2, one allows
// R20 - Switch interrupt cleared by bit 4 pulse
// R21 - Aux fault cleared by switch high/power low
// R22 - Main fault cleared by enables low/power low
// R23 - Switch low means slot populated
// R24 - Control bits 1 and 3 enable slots
// R25 - Reset clears faults, inputs synchronized (code synchronizes only the presence switches and power valid)
`timescale 1ns/1ps
module hpsfi_core #(
    parameter int NSLOT = 2
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // Register port from the serial engine
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // Supply monitors
    input  wire logic             main_12v_ok,
    input  wire logic             main_5v_ok,
    input  wire logic             main_3v3_input,
    input  wire logic             standby_3v3_input,
    input  wire logic             system_power_valid,
    input  wire logic             over_temp,
    // Per-slot inputs
    input  wire logic [NSLOT-1:0] slot_presence_switch,
    input  wire logic [NSLOT-1:0] slot_enable_pin,
    input  wire logic [NSLOT-1:0] gate_enhanced,
    input  wire logic [NSLOT-1:0] out_uv,
    input  wire logic [NSLOT-1:0] main_oc,
    input  wire logic [NSLOT-1:0] aux_main_over_slow,
    input  wire logic [NSLOT-1:0] aux_main_over_fast,
    input  wire logic [NSLOT-1:0] aux_stby_over,
    // Per-slot switch controls
    output logic      [NSLOT-1:0] main_switch_on,
    output logic      [NSLOT-1:0] main_discharge_on,
    output logic      [NSLOT-1:0] aux_stby_on,
    output logic      [NSLOT-1:0] aux_main_on,
    // Interrupt
    output logic                  irq_n
);
    import hpsfi_pkg::*;

    localparam int CW = 17;
    localparam logic [CW-1:0] LIM_SLOW = CW'(HPSFI_AUX_SLOW_CYC);
    localparam logic [CW-1:0] LIM_FAST = CW'(HPSFI_AUX_FAST_CYC);
    localparam logic [CW-1:0] LIM_STBY = CW'(HPSFI_STBY_OC_CYC);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]       ctrl;
        logic [NSLOT-1:0] sw_m;
        logic [NSLOT-1:0] sw_s;
        logic [NSLOT-1:0] sw_p;
        logic [NSLOT-1:0] en_prev;
        logic [1:0]       pv_m;
        logic             pv_s;
        logic             sby_prev;
        logic             main_prev;
        logic [NSLOT-1:0] main_flt;
        logic [NSLOT-1:0] uv_flt;
        logic [NSLOT-1:0] stby_flt;
        logic [NSLOT-1:0] amain_flt;
        logic [NSLOT-1:0] sw_irq;
        logic [NSLOT-1:0] main_on;
        logic [NSLOT-1:0] stby_on;
        logic [NSLOT-1:0] amain_on;
        logic             thermal;
        logic             irq_n;
    } hpsfi_state_t;

    hpsfi_state_t s_q, s_d;

    logic [NSLOT-1:0] trip_slow, trip_fast, trip_stby;

    // ****************************************
    // Overcurrent filters
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NSLOT; g++) begin : g_flt
            hpsfi_oc_filter #(.CNT_W(CW)) u_slow (
                .clk_sys (clk_sys),
                .srst    (srst),
                .over    (aux_main_over_slow[g] & s_q.amain_on[g]),
                .limit   (LIM_SLOW),
                .trip    (trip_slow[g])
            ); // R15
            hpsfi_oc_filter #(.CNT_W(CW)) u_fast (
                .clk_sys (clk_sys),
                .srst    (srst),
                .over    (aux_main_over_fast[g] & s_q.amain_on[g]),
                .limit   (LIM_FAST),
                .trip    (trip_fast[g])
            ); // R15
            hpsfi_oc_filter #(.CNT_W(CW)) u_stby (
                .clk_sys (clk_sys),
                .srst    (srst),
                .over    (aux_stby_over[g] & s_q.stby_on[g]),
                .limit   (LIM_STBY),
                .trip    (trip_stby[g])
            ); // R16
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************
    logic             inputs_ok, main_ok, pv_fall, sby_rise, main_rise;
    logic [NSLOT-1:0] sw_rise, sw_fall, sw_chg, en_bit, en_any, en_fall, slot_irq;
    logic [NSLOT-1:0] mask_bit;
    logic [7:0]       ctrl_w;

    always_comb begin
        s_d        = s_q;
        ctrl_w     = s_q.ctrl;
        mask_bit   = {s_q.ctrl[HPSFI_CTL_MASK_B], s_q.ctrl[HPSFI_CTL_MASK_A]}; // R19
        en_bit     = {s_q.ctrl[HPSFI_CTL_EN_B], s_q.ctrl[HPSFI_CTL_EN_A]}; // R24
        inputs_ok  = main_12v_ok & main_5v_ok & main_3v3_input;
        main_ok    = inputs_ok & s_q.pv_s;
        pv_fall    = s_q.pv_s & ~s_q.pv_m[1];
        sby_rise   = standby_3v3_input & ~s_q.sby_prev;
        main_rise  = inputs_ok & ~s_q.main_prev;
        // R25 synchronise switches and power valid
        s_d.sw_m   = slot_presence_switch;
        s_d.sw_s   = s_q.sw_m;
        s_d.sw_p   = s_q.sw_s;
        s_d.pv_m   = {s_q.pv_m[0], system_power_valid};
        s_d.pv_s   = s_q.pv_m[1];
        s_d.sby_prev  = standby_3v3_input;
        s_d.main_prev = inputs_ok;
        sw_rise    = s_q.sw_s & ~s_q.sw_p;
        sw_fall    = ~s_q.sw_s & s_q.sw_p;
        sw_chg     = sw_rise | sw_fall;
        en_any     = slot_enable_pin | en_bit;
        en_fall    = s_q.en_prev & ~en_any;
        s_d.en_prev = en_any;

        if (reg_wr && reg_addr == HPSFI_OFS_CTRL_WR) begin
            ctrl_w = reg_wdata;
        end
        s_d.ctrl = ctrl_w;

        s_d.thermal = over_temp; // R06
        for (int i = 0; i < NSLOT; i++) begin
            // Main faults: overload while main switch on, UV after enhancement
            if (!en_any[i] || pv_fall || en_fall[i]) begin
                s_d.main_flt[i] = 1'b0; // R07 R22
                s_d.uv_flt[i]   = 1'b0;
            end
            if (s_q.main_on[i] && main_oc[i]) begin
                s_d.main_flt[i] = 1'b1; // R04
            end
            if (s_q.main_on[i] && gate_enhanced[i] && out_uv[i]) begin
                s_d.uv_flt[i] = 1'b1; // R02 R03
            end
            s_d.main_on[i] = main_ok && en_any[i] && !s_q.main_flt[i] && !s_q.uv_flt[i]
                             && !over_temp; // R01 R05 R06

            // Aux faults
            if (sw_rise[i] || pv_fall || main_rise) begin
                s_d.amain_flt[i] = 1'b0; // R10 R21
            end
            if (sw_rise[i] || pv_fall || sby_rise) begin
                s_d.stby_flt[i] = 1'b0; // R09 R21
            end
            if (trip_slow[i] || trip_fast[i]) begin
                s_d.amain_flt[i] = 1'b1; // R10 R15
            end
            if (trip_stby[i]) begin
                s_d.stby_flt[i] = 1'b1; // R09 R16
            end

            // Aux source: break-before-make through one all-off cycle
            if (s_q.sw_s[i] || over_temp) begin
                s_d.stby_on[i]  = 1'b0; // R14 R23 R06
                s_d.amain_on[i] = 1'b0;
            end else if (main_ok && !s_q.amain_flt[i]) begin
                s_d.stby_on[i]  = 1'b0; // R12
                s_d.amain_on[i] = !s_q.stby_on[i];
            end else begin
                s_d.amain_on[i] = 1'b0; // R13
                s_d.stby_on[i]  = standby_3v3_input && !s_q.stby_flt[i] && !s_q.amain_on[i]; // R11
            end

            // Switch-change interrupt, held off while reset bit set
            if (s_q.ctrl[HPSFI_CTL_SW_RST]) begin
                s_d.sw_irq[i] = 1'b0; // R20
            end else if (sw_chg[i]) begin
                s_d.sw_irq[i] = 1'b1; // R20
            end
        end

        slot_irq = s_q.sw_irq | s_q.main_flt | s_q.uv_flt | s_q.amain_flt | s_q.stby_flt
                   | {NSLOT{s_q.thermal}}; // R17
        s_d.irq_n = ~|(slot_irq & mask_bit); // R18
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q       <= '0; // R25
            s_q.ctrl  <= HPSFI_CTL_RESET;
            s_q.sw_m  <= '1;
            s_q.sw_s  <= '1;
            s_q.sw_p  <= '1;
            s_q.irq_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs and readback
    // ****************************************
    assign main_switch_on    = s_q.main_on;
    assign main_discharge_on = ~s_q.main_on; // R08
    assign aux_stby_on       = s_q.stby_on;
    assign aux_main_on       = s_q.amain_on;
    assign irq_n             = s_q.irq_n;

    always_comb begin
        reg_rdata = 8'h00;
        if (reg_addr == HPSFI_OFS_STATUS) begin
            reg_rdata[HPSFI_ST_SYSTEM_POWER_VALID_A] = s_q.main_on[0] & gate_enhanced[0];
            reg_rdata[HPSFI_ST_AUXOK_A] = s_q.amain_on[0];
            reg_rdata[HPSFI_ST_IRQ_A]   = slot_irq[0]; // R18
            reg_rdata[HPSFI_ST_SYSTEM_POWER_VALID_B] = s_q.main_on[1] & gate_enhanced[1];
            reg_rdata[HPSFI_ST_AUXOK_B] = s_q.amain_on[1];
            reg_rdata[HPSFI_ST_IRQ_B]   = slot_irq[1]; // R18
            reg_rdata[HPSFI_ST_PVALID]  = s_q.pv_s;
        end else if (reg_addr == HPSFI_OFS_CTRL_RD) begin
            reg_rdata = s_q.ctrl;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_main_gate : assert property (@(posedge clk_sys) disable iff (srst)
        main_switch_on[0] |-> $past(s_q.pv_s) && $past(en_any[0])) // R01
        else $error("main on without power valid and enable");
    a_therm_off : assert property (@(posedge clk_sys) disable iff (srst)
        over_temp |=> main_switch_on == '0 && aux_stby_on == '0 && aux_main_on == '0) // R06
        else $error("switch on during overtemperature");
    a_oc_latch : assert property (@(posedge clk_sys) disable iff (srst)
        main_switch_on[0] && main_oc[0] && en_any[0] && !pv_fall |=> s_q.main_flt[0] ##1 !main_switch_on[0]) // R05
        else $error("overload did not shut slot");
    a_bbm_aux : assert property (@(posedge clk_sys) disable iff (srst)
        !(aux_stby_on[0] && aux_main_on[0]) && !(aux_stby_on[1] && aux_main_on[1])) // R12
        else $error("both aux sources on");
    a_sw_off : assert property (@(posedge clk_sys) disable iff (srst)
        sw_rise[0] |=> !aux_stby_on[0] && !aux_main_on[0]) // R14
        else $error("aux stayed on after switch rise");
    a_irq_mask : assert property (@(posedge clk_sys) disable iff (srst)
        mask_bit == '0 |=> irq_n) // R19
        else $error("masked interrupt reached pin");
    a_swirq_hold : assert property (@(posedge clk_sys) disable iff (srst)
        s_q.ctrl[HPSFI_CTL_SW_RST] |=> s_q.sw_irq == '0) // R20
        else $error("switch interrupt set while reset bit high");
    a_discharge : assert property (@(posedge clk_sys) disable iff (srst)
        $fell(main_switch_on[1]) |-> main_discharge_on[1]) // R08
        else $error("discharge not applied at turn-off");
    a_pv_clear : assert property (@(posedge clk_sys) disable iff (srst)
        pv_fall && (s_q.main_on & main_oc) == '0 && (trip_slow | trip_fast) == '0
        |=> s_q.main_flt == '0 && s_q.amain_flt == '0) // R22
        else $error("power valid fall did not clear faults");

endmodule : hpsfi_core

// File: bench/hpsfi_host_model.sv
// Host controller and slot presence switch model for the hot-plug fault logic
`timescale 1ns/1ps
module hpsfi_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output logic            reg_wr,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // Presence switches
    output logic [1:0]      slot_presence_switch
);
    import hpsfi_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_addr = HPSFI_OFS_STATUS;
        reg_wdata = 8'h00;
        slot_presence_switch = 2'b11;
    end
    // Called just after a falling edge; strobe stands over one rising edge
    task automatic wr(input logic [7:0] d);
        reg_addr = HPSFI_OFS_CTRL_WR;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = HPSFI_OFS_STATUS;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic clr_sw(input logic [7:0] keep);
        wr(keep | 8'h10);
        @(negedge clk_sys);
        wr(keep);
    endtask : clr_sw
    // Low means a card is seated
    task automatic seat(input logic [1:0] pop);
        slot_presence_switch = ~pop;
    endtask : seat
endmodule : hpsfi_host_model

// File: bench/hpsfi_core_tb.sv
// Self-checking testbench for the hot-plug fault and interrupt logic
`timescale 1ns/1ps
module hpsfi_core_tb;
    import hpsfi_pkg::*;
    logic       clk_sys, srst, reg_wr, m12, m5, m3, stb, pv, ot, irq_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [1:0] sw, en_pin, genh, ouv, moc, aslow, afast, astb, mon, dis, ason, amon;
    int         err_count, compares, cyc;

    hpsfi_core hpsfi_core_i (.clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .main_12v_ok(m12), .main_5v_ok(m5),
        .main_3v3_input(m3), .standby_3v3_input(stb), .system_power_valid(pv), .over_temp(ot),
        .slot_presence_switch(sw), .slot_enable_pin(en_pin), .gate_enhanced(genh), .out_uv(ouv),
        .main_oc(moc), .aux_main_over_slow(aslow), .aux_main_over_fast(afast), .aux_stby_over(astb),
        .main_switch_on(mon), .main_discharge_on(dis), .aux_stby_on(ason), .aux_main_on(amon),
        .irq_n(irq_n));
    hpsfi_host_model hpsfi_host_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slot_presence_switch(sw));

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // Both aux sources never on together
    always @(negedge clk_sys) begin
        if (srst === 1'b0 && (ason & amon) !== 2'b00) begin
            err_count++;
            $display("MISMATCH aux_overlap expected 00 seen %b", ason & amon);
        end
    end
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt
    task automatic st();
        hpsfi_host_model_i.rd(HPSFI_OFS_STATUS, v);
    endtask : st
    task automatic do_reset();
        srst = 1'b1;
        {m12, m5, m3, stb, pv, ot} = 6'b111110;
        {en_pin, genh, ouv, moc, aslow, afast, astb} = '0;
        hpsfi_host_model_i.seat(2'b00);
        wt(5);
        srst = 1'b0;
        wt(4);
    endtask : do_reset

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        do_reset();
        chk("main_on", 8'h00, mon);
        chk("discharge", 8'h03, dis);
        chk("irq_n", 8'h01, irq_n);
        hpsfi_host_model_i.rd(HPSFI_OFS_CTRL_RD, v);
        chk("ctrl", HPSFI_CTL_RESET, v);
        hpsfi_host_model_i.rd(8'h20, v);
        chk("unmapped", 8'h00, v);
    endtask : t_reset
    task automatic t_enable();
        do_reset();
        pv = 1'b0;
        hpsfi_host_model_i.wr(8'h02);
        wt(6);
        chk("main_a_nopv", 8'h00, mon[0]);
        pv = 1'b1;
        wt(6);
        chk("main_a", 8'h01, mon);
        chk("dis", 8'h02, dis);
        hpsfi_host_model_i.wr(8'h00);
        wt(4);
        chk("main_off", 8'h00, mon);
        chk("dis_off", 8'h03, dis);
    endtask : t_enable
    task automatic t_fault();
        do_reset();
        hpsfi_host_model_i.wr(8'h0A);
        wt(6);
        moc = 2'b01;
        wt(2);
        moc = 2'b00;
        wt(20);
        chk("main_fault", 8'h02, mon);
        st();
        chk("irq_a", 8'h01, v[HPSFI_ST_IRQ_A]);
        chk("irq_n_masked", 8'h01, irq_n);
        hpsfi_host_model_i.wr(8'h08);
        wt(4);
        st();
        chk("irq_a_clr", 8'h00, v[HPSFI_ST_IRQ_A]);
        hpsfi_host_model_i.wr(8'h0A);
        wt(6);
        chk("main_again", 8'h03, mon);
    endtask : t_fault
    task automatic t_uv();
        do_reset();
        hpsfi_host_model_i.wr(8'h02);
        wt(6);
        ouv = 2'b01;
        wt(6);
        chk("uv_ignored", 8'h01, mon[0]);
        genh = 2'b01;
        wt(4);
        chk("uv_trip", 8'h00, mon[0]);
    endtask : t_uv
    task automatic t_temp();
        do_reset();
        hpsfi_host_model_i.seat(2'b01);
        hpsfi_host_model_i.wr(8'h0A);
        wt(8);
        chk("both_on", 8'h03, mon);
        chk("aux_a", 8'h01, amon[0] | ason[0]);
        ot = 1'b1;
        wt(4);
        chk("temp_off", 8'h00, {mon, amon, ason});
        st();
        chk("temp_irq", 8'h03, {v[HPSFI_ST_IRQ_B], v[HPSFI_ST_IRQ_A]});
    endtask : t_temp
    task automatic t_swirq();
        do_reset();
        hpsfi_host_model_i.wr(8'h01);
        hpsfi_host_model_i.seat(2'b01);
        wt(8);
        chk("sw_irq", 8'h00, irq_n);
        hpsfi_host_model_i.clr_sw(8'h01);
        wt(3);
        chk("sw_clr", 8'h01, irq_n);
        hpsfi_host_model_i.seat(2'b11);
        wt(8);
        chk("b_masked", 8'h01, irq_n);
        st();
        chk("irq_b", 8'h01, v[HPSFI_ST_IRQ_B]);
        hpsfi_host_model_i.wr(8'h05);
        wt(3);
        chk("b_unmasked", 8'h00, irq_n);
    endtask : t_swirq
    task automatic t_aux();
        do_reset();
        {m12, m5, m3} = 3'b000;
        hpsfi_host_model_i.seat(2'b01);
        wt(8);
        chk("aux_stby", 8'h01, {amon[0], ason[0]});
        {m12, m5, m3} = 3'b111;
        wt(8);
        chk("aux_to_main", 8'h02, {amon[0], ason[0]});
        m3 = 1'b0;
        wt(8);
        chk("aux_back", 8'h01, {amon[0], ason[0]});
        hpsfi_host_model_i.seat(2'b00);
        wt(8);
        chk("aux_empty", 8'h00, {amon[0], ason[0]});
    endtask : t_aux
    task automatic t_stby_oc();
        do_reset();
        {m12, m5, m3} = 3'b000;
        hpsfi_host_model_i.seat(2'b01);
        wt(8);
        astb = 2'b01;
        wt(HPSFI_STBY_OC_CYC - 3);
        chk("stby_hold", 8'h01, ason[0]);
        wt(8);
        chk("stby_trip", 8'h00, ason[0]);
        astb = 2'b00;
        wt(6);
        chk("stby_latch", 8'h00, ason[0]);
        hpsfi_host_model_i.seat(2'b00);
        wt(8);
        hpsfi_host_model_i.seat(2'b01);
        wt(8);
        chk("stby_rearm", 8'h01, ason[0]);
    endtask : t_stby_oc
    task automatic t_fast_oc();
        do_reset();
        hpsfi_host_model_i.seat(2'b01);
        wt(8);
        afast = 2'b01;
        wt(HPSFI_AUX_FAST_CYC - 3);
        chk("fast_hold", 8'h01, amon[0]);
        wt(8);
        chk("fast_trip", 8'h00, amon[0]);
        afast = 2'b00;
        wt(6);
        chk("fast_latch", 8'h00, amon[0]);
        st();
        chk("auxgood_a", 8'h00, v[HPSFI_ST_AUXOK_A]);
    endtask : t_fast_oc
    task automatic t_pins();
        do_reset();
        en_pin = 2'b11;
        wt(6);
        chk("pin_enable", 8'h03, mon);
        moc = 2'b10;
        wt(4);
        chk("b_overload", 8'h01, mon);
        moc = 2'b00;
        en_pin = 2'b01;
        wt(4);
        en_pin = 2'b11;
        wt(4);
        chk("pin_cycle", 8'h03, mon);
        genh = 2'b11;
        ouv = 2'b10;
        wt(4);
        chk("b_uv", 8'h01, mon);
        ouv = 2'b00;
        pv = 1'b0;
        wt(8);
        st();
        chk("pv_low_clr", 8'h00, {v[HPSFI_ST_IRQ_B], mon});
        pv = 1'b1;
        wt(8);
        chk("pv_back", 8'h03, mon);
        hpsfi_host_model_i.seat(2'b01);
        {aslow, afast, astb} = 6'b111010;
        wt(HPSFI_AUX_FAST_CYC + 50);
        chk("slow_hold", 8'h01, amon);
        {aslow, afast, astb} = '0;
        {m12, m5, m3} = 3'b000;
        wt(4);
        stb = 1'b0;
        wt(4);
        chk("stby_gone", 8'h00, {amon[0], ason[0]});
        stb = 1'b1;
        wt(4);
        chk("stby_back", 8'h01, {amon[0], ason[0]});
    endtask : t_pins

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        err_count = 0;
        compares = 0;
        cyc = 0;
        t_reset();
        t_enable();
        t_fault();
        t_uv();
        t_temp();
        t_swirq();
        t_aux();
        t_stby_oc();
        t_fast_oc();
        t_pins();
        stop_test();
    end
endmodule : hpsfi_core_tb
